// ==== rtl/rsb_pkg.sv ====
// Package for the receive signaling buffer: register map, field layout, reset values.
// Assumes an 8-bit register port and a 5-bit timeslot number from the framer.
package rsb_pkg;
	// Register offsets
	localparam logic [7:0] OFF_CONFIG  = 8'hD2;
	localparam logic [7:0] OFF_STATUS  = 8'hD3;
	localparam logic [7:0] OFF_CONTROL = 8'hD4;
	localparam logic [7:0] OFF_DATA    = 8'hD5;
	localparam logic [7:0] OFF_FLAGS0  = 8'hD6;
	localparam logic [7:0] OFF_FLAGS1  = 8'hD7;
	localparam logic [7:0] OFF_FLAGS2  = 8'hD8;
	localparam logic [7:0] OFF_FLAGS3  = 8'hD9;
	// Configuration field positions
	localparam int CFG_FREEZE_BIT = 3;
	localparam int CFG_DEB_BIT    = 2;
	localparam int CFG_IRQ_BIT    = 1;
	localparam logic [7:0] CFG_MASK = 8'h0E;
	// Control field position
	localparam int CTL_RNW_BIT = 7;
	// Indirect location field
	localparam int LOC_EXTRACT_BIT = 4;
	// Reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [3:0] RST_NIB  = 4'h0;
	// Wait cycles of an indirect operation before its transfer; busy stays high one cycle longer
	localparam logic [1:0] BUSY_CYCLES = 2'h2;
	// Mask of the flags in the last indication register
	localparam logic [7:0] FLAGS3_MASK = 8'h1F;

	typedef enum logic [1:0] {RSB_IDLE, RSB_WAIT, RSB_DONE} rsb_state_t;

	// Register port request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} rsb_bus_t;

	// Codeword from the framer
	typedef struct packed {
		logic       valid;
		logic [4:0] ts;
		logic [3:0] abcd;
	} rsb_sig_t;
endpackage

// ==== rtl/rsb_slot.sv ====
// One timeslot of the signaling store: debounce, freeze, change detect.
// Assumes codewords arrive one per clock at most, tagged for this slot.
`timescale 1ns/1ns
module rsb_slot (
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic       cw_valid,
	input  wire logic [3:0] cw_abcd,
	input  wire logic       extract,
	input  wire logic       sync,
	input  wire logic       freeze,
	input  wire logic       debounce,
	output logic [3:0]      abcd,
	output logic            changed
);
	logic [3:0] last_r;
	logic [3:0] abcd_r;
	logic       chg_r;
	wire        take   = cw_valid && extract && sync && !freeze;     // RULE1 RULE17
	wire        stable = !debounce || (cw_abcd == last_r);          // RULE2
	wire        upd    = take && stable;

	// Store nibble and pulse a change only on a real new value
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			last_r <= rsb_pkg::RST_NIB;
			abcd_r <= rsb_pkg::RST_NIB;
			chg_r  <= 1'b0;
		end
		else
		begin
			if (cw_valid)
				last_r <= cw_abcd;
			if (upd)
				abcd_r <= cw_abcd;
			chg_r <= upd && (cw_abcd != abcd_r);                    // RULE18
		end
	end
	assign abcd    = abcd_r;
	assign changed = chg_r;

	// Checks: freeze holds, a lone codeword is filtered, flags mean a real change
	property p_freeze;
		@(posedge clk) disable iff (!rstn) freeze |=> abcd_r == $past(abcd_r);
	endproperty
	a_freeze: assert property (p_freeze) // RULE1
		else $error("nibble moved under freeze");
	property p_debounce;
		@(posedge clk) disable iff (!rstn) (debounce && cw_valid && cw_abcd != last_r)
			|=> abcd_r == $past(abcd_r);
	endproperty
	a_debounce: assert property (p_debounce) // RULE2
		else $error("debounce let a lone codeword through");
	property p_change;
		@(posedge clk) disable iff (!rstn) changed |-> abcd_r != $past(abcd_r);
	endproperty
	a_change: assert property (p_change) // RULE18
		else $error("change flagged without a new value");
endmodule

// ==== rtl/rsb_top.sv ====
// Receive E1 signaling buffer: config, indirect access port, change flags, interrupt.
// Assumes framer codewords are synchronous to clk and the host keeps the busy protocol.
// Function
// [RULE1] Freeze holds every stored ABCD nibble unchanged.
// [RULE2] Debounce updates only after two identical consecutive codewords.
// [RULE3] Interrupt asserts when enabled and any change flag is set.
// [RULE4] Busy reads 1 during an indirect operation, else 0.
// [RULE5] Host starts no indirect operation while busy.
// [RULE6] Control bit 7: 0 writes data register, 1 reads target.
// [RULE7] Target address covers 01h-0Fh and 11h-1Fh only.
// [RULE8] Indirect write: load data register, then write control with bit 7 low.
// [RULE9] Indirect read: write control with bit 7 high; data register receives byte.
// [RULE10] A timeslot change sets its change flag; a change in timeslot 31 sets no flag, since no flag bit maps it.
// [RULE11] Writing 1 clears a flag, 0 leaves it; flags reset to 0.
// [RULE12] Flags register 0 bits 7..0 report timeslots 8..1.
// [RULE13] Flags register 1: bit 7 timeslot 17, bits 6..0 timeslots 15..9.
// [RULE14] Flags register 2 bits 7..0 report timeslots 25..18.
// [RULE15] Flags register 3 bits 4..0 report timeslots 30..26.
// [RULE16] Each indirect location serves one timeslot 1-15 or 17-31.
// [RULE17] Location bit 4 enables extraction into read-only bits 3..0.
// [RULE18] A flag rises only when the stored nibble really changes.
// [RULE19] Only control writes start operations; writes while busy are ignored.
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ns
module rsb_top (
	input  wire logic              clk,
	input  wire logic              rstn,
	input  wire rsb_pkg::rsb_bus_t bus,
	input  wire rsb_pkg::rsb_sig_t sig,
	input  wire logic              mf_sync,
	output logic [7:0]             rdata,
	output logic                   irq
);
	logic [7:0]          cfg_r;
	logic [7:0]          ctl_r;
	logic [7:0]          dat_r;
	logic [31:0]         ext_r;
	logic [31:0]         flag_r;
	logic [7:0]          rdata_r;
	logic                irq_r;
	logic [1:0]          cnt_r;
	rsb_pkg::rsb_state_t st_r;
	logic [3:0]          nib   [32];
	logic [31:0]         chg;

	// Valid timeslot: 1..15 and 17..31
	function automatic logic ts_ok(input logic [6:0] a);
		ts_ok = (a[6:5] == 2'h0) && (a[3:0] != 4'h0);
	endfunction

	wire       busy    = (st_r != rsb_pkg::RSB_IDLE);                // RULE4
	wire       wr_cfg  = bus.wr && (bus.addr == rsb_pkg::OFF_CONFIG);
	wire       wr_ctl  = bus.wr && (bus.addr == rsb_pkg::OFF_CONTROL);
	wire       wr_dat  = bus.wr && (bus.addr == rsb_pkg::OFF_DATA);
	wire       start   = wr_ctl && !busy;                           // RULE19
	wire [4:0] tgt     = ctl_r[4:0];
	wire       tgt_ok  = ts_ok(ctl_r[6:0]);                         // RULE7
	wire       is_rd   = ctl_r[rsb_pkg::CTL_RNW_BIT];               // RULE6
	wire       freeze  = cfg_r[rsb_pkg::CFG_FREEZE_BIT];
	wire       deb     = cfg_r[rsb_pkg::CFG_DEB_BIT];
	wire       irq_en  = cfg_r[rsb_pkg::CFG_IRQ_BIT];
	wire [7:0] loc_rd  = {3'h0, ext_r[tgt], nib[tgt]};              // RULE17
	wire [7:0] w1c [4];
	assign w1c[0] = (bus.wr && bus.addr == rsb_pkg::OFF_FLAGS0) ? bus.wdata : 8'h00;
	assign w1c[1] = (bus.wr && bus.addr == rsb_pkg::OFF_FLAGS1) ? bus.wdata : 8'h00;
	assign w1c[2] = (bus.wr && bus.addr == rsb_pkg::OFF_FLAGS2) ? bus.wdata : 8'h00;
	assign w1c[3] = (bus.wr && bus.addr == rsb_pkg::OFF_FLAGS3) ?
		(bus.wdata & rsb_pkg::FLAGS3_MASK) : 8'h00;

	// Flag bit order: flag n at index n-1, mapped to its timeslot
	wire [31:0] evt = {3'h0, chg[30:26], chg[25:18],         // RULE14 RULE15
		chg[17], chg[15:9], chg[8:1]};                       // RULE12 RULE13
	wire [31:0] clr = {w1c[3], w1c[2], w1c[1], w1c[0]};
	wire [31:0] flag_nxt = (flag_r & ~clr) | evt;                   // RULE10 RULE11

	// One store per timeslot; 0 and 16 carry no channel signaling
	genvar g;
	generate
		for (g = 0; g < 32; g++)
		begin : g_slot
			if (g == 0 || g == 16)
			begin : g_none
				assign nib[g] = rsb_pkg::RST_NIB;
				assign chg[g] = 1'b0;
			end
			else
			begin : g_ts
				rsb_slot u_slot (
					.clk      (clk),
					.rstn     (rstn),
					.cw_valid (sig.valid && sig.ts == 5'(g)),         // RULE16
					.cw_abcd  (sig.abcd),
					.extract  (ext_r[g]),
					.sync     (mf_sync),
					.freeze   (freeze),
					.debounce (deb),
					.abcd     (nib[g]),
					.changed  (chg[g])
				);
			end
		end
	endgenerate

	// Read mux; unmapped reads return zero
	logic [7:0] rd_mux;
	always_comb
	begin
		case (bus.addr)
			rsb_pkg::OFF_CONFIG:  rd_mux = cfg_r & rsb_pkg::CFG_MASK;
			rsb_pkg::OFF_STATUS:  rd_mux = {7'h00, busy};
			rsb_pkg::OFF_CONTROL: rd_mux = ctl_r;
			rsb_pkg::OFF_DATA:    rd_mux = dat_r;
			rsb_pkg::OFF_FLAGS0:  rd_mux = flag_r[7:0];
			rsb_pkg::OFF_FLAGS1:  rd_mux = flag_r[15:8];
			rsb_pkg::OFF_FLAGS2:  rd_mux = flag_r[23:16];
			rsb_pkg::OFF_FLAGS3:  rd_mux = flag_r[31:24];
			default:              rd_mux = 8'h00;
		endcase
	end

	// Host registers and flags
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			cfg_r   <= rsb_pkg::RST_BYTE;
			ctl_r   <= rsb_pkg::RST_BYTE;
			flag_r  <= 32'h0000_0000;
			rdata_r <= rsb_pkg::RST_BYTE;
			irq_r   <= 1'b0;
		end
		else
		begin
			if (wr_cfg)
				cfg_r <= bus.wdata & rsb_pkg::CFG_MASK;
			if (start)
				ctl_r <= bus.wdata;                                  // RULE19
			flag_r  <= flag_nxt;
			rdata_r <= bus.rd ? rd_mux : 8'h00;
			irq_r   <= irq_en && (flag_nxt != 32'h0000_0000);       // RULE3
		end
	end

	// Indirect engine: a fixed busy time, then the transfer
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			st_r  <= rsb_pkg::RSB_IDLE;
			cnt_r <= 2'h0;
			dat_r <= rsb_pkg::RST_BYTE;
			ext_r <= 32'h0000_0000;
		end
		else
		begin
			case (st_r)
				rsb_pkg::RSB_IDLE:
				begin
					if (wr_dat)
						dat_r <= bus.wdata;                          // RULE8
					if (start)
					begin
						st_r  <= rsb_pkg::RSB_WAIT;
						cnt_r <= rsb_pkg::BUSY_CYCLES;
					end
				end
				rsb_pkg::RSB_WAIT:
				begin
					cnt_r <= cnt_r - 2'h1;
					if (cnt_r == 2'h1)
						st_r <= rsb_pkg::RSB_DONE;
				end
				rsb_pkg::RSB_DONE:
				begin
					if (is_rd)
						dat_r <= tgt_ok ? loc_rd : 8'h00;            // RULE9
					else if (tgt_ok)
						ext_r[tgt] <= dat_r[rsb_pkg::LOC_EXTRACT_BIT]; // RULE6
					st_r <= rsb_pkg::RSB_IDLE;
				end
				default: st_r <= rsb_pkg::RSB_IDLE;
			endcase
		end
	end

	assign rdata = rdata_r;
	assign irq   = irq_r;

	// Checks: busy timing and the busy handshake
	property p_busy_after_start;
		@(posedge clk) disable iff (!rstn) start |=> busy[*3] ##1 !busy;
	endproperty
	a_busy_after_start: assert property (p_busy_after_start) // RULE4
		else $error("busy length wrong");
	property p_status_read;
		@(posedge clk) disable iff (!rstn) (bus.rd && bus.addr == rsb_pkg::OFF_STATUS)
			|=> rdata == {7'h00, $past(busy)};
	endproperty
	a_status_read: assert property (p_status_read) // RULE4
		else $error("status does not show busy");
	property p_start_busy;
		@(posedge clk) disable iff (!rstn) start |=> busy && ctl_r == $past(bus.wdata);
	endproperty
	a_start_busy: assert property (p_start_busy) // RULE19
		else $error("control write did not launch");
	property p_ignore_busy;
		@(posedge clk) disable iff (!rstn) (wr_ctl && busy) |=> ctl_r == $past(ctl_r);
	endproperty
	a_ignore_busy: assert property (p_ignore_busy) // RULE19
		else $error("control changed while busy");
	property p_dat_hold;
		@(posedge clk) disable iff (!rstn) (wr_dat && st_r == rsb_pkg::RSB_WAIT) |=> dat_r == $past(dat_r);
	endproperty
	a_dat_hold: assert property (p_dat_hold)
		else $error("data register written while busy");

	// Checks: indirect transfers
	property p_read_data;
		@(posedge clk) disable iff (!rstn) (st_r == rsb_pkg::RSB_DONE && is_rd && tgt_ok)
			|=> dat_r[3:0] == $past(nib[tgt]);
	endproperty
	a_read_data: assert property (p_read_data) // RULE9
		else $error("indirect read wrong");
	property p_read_zero;
		@(posedge clk) disable iff (!rstn) (st_r == rsb_pkg::RSB_DONE && is_rd && !tgt_ok)
			|=> dat_r == 8'h00;
	endproperty
	a_read_zero: assert property (p_read_zero) // RULE7
		else $error("read of a bad target not zero");
	property p_ext_write;
		@(posedge clk) disable iff (!rstn) (st_r == rsb_pkg::RSB_DONE && !is_rd && tgt_ok)
			|=> ext_r[tgt] == $past(dat_r[rsb_pkg::LOC_EXTRACT_BIT]);
	endproperty
	a_ext_write: assert property (p_ext_write) // RULE8
		else $error("indirect write lost");
	property p_bad_target;
		@(posedge clk) disable iff (!rstn) (st_r == rsb_pkg::RSB_DONE && !is_rd && !tgt_ok)
			|=> ext_r == $past(ext_r);
	endproperty
	a_bad_target: assert property (p_bad_target) // RULE7
		else $error("write to a bad target landed");

	// Checks: change flags and their mapping
	property p_w1c;
		@(posedge clk) disable iff (!rstn) (w1c[0][0] && !evt[0]) |=> !flag_r[0];
	endproperty
	a_w1c: assert property (p_w1c) // RULE11
		else $error("flag not cleared");
	property p_set_wins;
		@(posedge clk) disable iff (!rstn) evt[0] |=> flag_r[0];
	endproperty
	a_set_wins: assert property (p_set_wins) // RULE10
		else $error("flag event lost");
	property p_map0;
		@(posedge clk) disable iff (!rstn) chg[8:1] != 8'h00
			|=> (flag_r[7:0] & $past(chg[8:1])) == $past(chg[8:1]);
	endproperty
	a_map0: assert property (p_map0) // RULE12
		else $error("timeslot 1 to 8 flag missing");
	property p_map1;
		@(posedge clk) disable iff (!rstn) chg[15:9] != 7'h00
			|=> (flag_r[14:8] & $past(chg[15:9])) == $past(chg[15:9]);
	endproperty
	a_map1: assert property (p_map1) // RULE13
		else $error("timeslot 9 to 15 flag missing");
	property p_map17;
		@(posedge clk) disable iff (!rstn) chg[17] |=> flag_r[15];
	endproperty
	a_map17: assert property (p_map17) // RULE13
		else $error("timeslot 17 flag missing");
	property p_map2;
		@(posedge clk) disable iff (!rstn) chg[25:18] != 8'h00
			|=> (flag_r[23:16] & $past(chg[25:18])) == $past(chg[25:18]);
	endproperty
	a_map2: assert property (p_map2) // RULE14
		else $error("timeslot 18 to 25 flag missing");
	property p_map3;
		@(posedge clk) disable iff (!rstn) chg[30:26] != 5'h00
			|=> (flag_r[28:24] & $past(chg[30:26])) == $past(chg[30:26]);
	endproperty
	a_map3: assert property (p_map3) // RULE15
		else $error("timeslot 26 to 30 flag missing");
	property p_flags3_top;
		@(posedge clk) disable iff (!rstn) flag_r[31:29] == 3'h0;
	endproperty
	a_flags3_top: assert property (p_flags3_top) // RULE15
		else $error("unused flag bit set");

	// Checks: interrupt and read port
	property p_irq;
		@(posedge clk) disable iff (!rstn) irq |-> (irq_en || $past(irq_en)) && flag_r != 0;
	endproperty
	a_irq: assert property (p_irq) // RULE3
		else $error("irq without flag");
	property p_irq_off;
		@(posedge clk) disable iff (!rstn) (!irq_en && $stable(irq_en)) |=> !irq;
	endproperty
	a_irq_off: assert property (p_irq_off) // RULE3
		else $error("irq while disabled");
	property p_irq_on;
		@(posedge clk) disable iff (!rstn) (irq_en && (flag_r & ~clr) != 32'h0000_0000)
			|=> irq;
	endproperty
	a_irq_on: assert property (p_irq_on) // RULE3
		else $error("irq missing with a flag set");
	property p_rdata_zero;
		@(posedge clk) disable iff (!rstn) !bus.rd |=> rdata == 8'h00;
	endproperty
	a_rdata_zero: assert property (p_rdata_zero)
		else $error("rdata outside read");

	// Coverage of the main scenarios
	c_read: cover property (@(posedge clk) start && bus.wdata[7]);
	c_write: cover property (@(posedge clk) start && !bus.wdata[7]);
	c_irq: cover property (@(posedge clk) irq);
	c_flag_clear: cover property (@(posedge clk) (flag_r & clr) != 32'h0000_0000);
	c_bad_target: cover property (@(posedge clk) st_r == rsb_pkg::RSB_DONE && !tgt_ok);
endmodule

// ==== tb/rsb_framer_model.sv ====
// Receive framer model: one signaling codeword per send request.
// Assumes the bench calls send() and that codewords share clk.
`timescale 1ns/1ns
module rsb_framer_model (
	input  wire logic         clk,
	output rsb_pkg::rsb_sig_t sig
);
	initial
	begin
		sig = '0;
	end
	// Idle lines carry the inverse, so a stale word never looks valid
	task automatic send(input logic [4:0] ts, input logic [3:0] abcd);
	begin
		@(posedge clk);
		sig <= {1'b1, ts, abcd};
		@(posedge clk);
		sig <= {1'b0, ~ts, ~abcd};
		repeat (3) @(posedge clk);
	end
	endtask
endmodule

// ==== tb/rsb_top_bench.sv ====
// Bench for the signaling buffer: register port tasks and scenarios.
// Assumes rsb_top with its own assertions and the framer model.
`timescale 1ns/1ns
module rsb_top_bench;
	logic              clk;
	logic              rstn;
	logic              mf_sync;
	rsb_pkg::rsb_bus_t bus;
	rsb_pkg::rsb_sig_t sig;
	logic [7:0]        rdata;
	logic              irq;
	logic [7:0]        v;
	int                num_errors;
	int                n_checks;

	rsb_top rsb_top_inst (.clk(clk), .rstn(rstn), .bus(bus), .sig(sig),
		.mf_sync(mf_sync), .rdata(rdata), .irq(irq));
	rsb_framer_model rsb_framer_model_inst (.clk(clk), .sig(sig));

	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic report_and_stop();
	begin
		$display("errors %0d checks %0d", num_errors, n_checks);
		if (num_errors == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	end
	endtask

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
	begin
		n_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
	begin
		@(posedge clk);
		bus <= {a, d, 1'b1, 1'b0};
		@(posedge clk);
		bus <= '0;
	end
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
	begin
		@(posedge clk);
		bus <= {a, 8'h00, 1'b0, 1'b1};
		@(posedge clk);
		bus <= '0;
		#1;
		d = rdata;
	end
	endtask

	// Bounded busy poll; a hang ends the run
	task automatic idle();
	int i;
	begin
		for (i = 0; i < 20; i++)
		begin
			rd(rsb_pkg::OFF_STATUS, v);
			if (v === 8'h00)
				return;
		end
		num_errors++;
		report_and_stop();
	end
	endtask

	task automatic ind(input logic [7:0] ctl);
	begin
		wr(rsb_pkg::OFF_CONTROL, ctl);
		rd(rsb_pkg::OFF_STATUS, v);
		chk(v, 8'h01);
		idle();
	end
	endtask

	task automatic ird(input logic [6:0] loc, input logic [7:0] exp);
	begin
		ind({1'b1, loc});
		rd(rsb_pkg::OFF_DATA, v);
		chk(v, exp);
	end
	endtask

	task automatic on(input logic [6:0] loc);
	begin
		wr(rsb_pkg::OFF_DATA, 8'h10);
		ind({1'b0, loc});
	end
	endtask

	task automatic t_reset();
	int i;
	begin
		for (i = 'hD2; i <= 'hD9; i++)
		begin
			rd(8'(i), v);
			chk(v, 8'h00);
		end
		rd(8'hE0, v);
		chk(v, 8'h00);
	end
	endtask

	// Extraction, flag, interrupt gating, write-one-to-clear
	task automatic t_change();
	begin
		on(7'h05);
		ird(7'h05, 8'h10);
		rsb_framer_model_inst.send(5'h05, 4'hA);
		ird(7'h05, 8'h1A);
		rd(rsb_pkg::OFF_FLAGS0, v);
		chk(v, 8'h10);
		chk({7'h00, irq}, 8'h00);
		wr(rsb_pkg::OFF_CONFIG, 8'h02);
		rd(rsb_pkg::OFF_CONFIG, v);
		chk(v, 8'h02);
		chk({7'h00, irq}, 8'h01);
		wr(rsb_pkg::OFF_FLAGS0, 8'hEF);
		rd(rsb_pkg::OFF_FLAGS0, v);
		chk(v, 8'h10);
		wr(rsb_pkg::OFF_FLAGS0, 8'h10);
		rd(rsb_pkg::OFF_FLAGS0, v);
		chk(v, 8'h00);
		chk({7'h00, irq}, 8'h00);
	end
	endtask

	// First differing word is held back by debounce; freeze hides change
	task automatic t_filter();
	begin
		wr(rsb_pkg::OFF_CONFIG, 8'h04);
		rsb_framer_model_inst.send(5'h05, 4'h3);
		ird(7'h05, 8'h1A);
		rsb_framer_model_inst.send(5'h05, 4'h3);
		ird(7'h05, 8'h13);
		wr(rsb_pkg::OFF_FLAGS0, 8'h10);
		wr(rsb_pkg::OFF_CONFIG, 8'h08);
		rsb_framer_model_inst.send(5'h05, 4'h7);
		ird(7'h05, 8'h13);
		rd(rsb_pkg::OFF_FLAGS0, v);
		chk(v, 8'h00);
		wr(rsb_pkg::OFF_CONFIG, 8'h00);
		// Out of multiframe sync a codeword must not reach the store
		mf_sync <= 1'b0;
		rsb_framer_model_inst.send(5'h05, 4'h9);
		mf_sync <= 1'b1;
		ird(7'h05, 8'h13);
	end
	endtask

	task automatic t_map();
	logic [6:0] loc [4] = '{7'h09, 7'h11, 7'h12, 7'h1A};
	logic [7:0] ra [4] = '{8'hD7, 8'hD7, 8'hD8, 8'hD9};
	logic [7:0] bm [4] = '{8'h01, 8'h80, 8'h01, 8'h01};
	int i;
	begin
		for (i = 0; i < 4; i++)
		begin
			on(loc[i]);
			rsb_framer_model_inst.send(loc[i][4:0], 4'h5);
			rd(ra[i], v);
			chk(v, bm[i]);
			wr(ra[i], bm[i]);
		end
	end
	endtask

	// A control write while busy must not launch a write to slot 6
	task automatic t_refuse();
	begin
		wr(rsb_pkg::OFF_CONTROL, 8'h85);
		wr(rsb_pkg::OFF_CONTROL, 8'h06);
		idle();
		ird(7'h06, 8'h00);
		ird(7'h10, 8'h00);
	end
	endtask

	initial
	begin
		rstn = 1'b0;
		mf_sync = 1'b1;
		bus = '0;
		num_errors = 0;
		n_checks = 0;
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		t_reset();
		t_change();
		t_filter();
		t_map();
		t_refuse();
		report_and_stop();
	end
endmodule
